//--- owcd_defs.vh
// Purpose: constants for the option word decoder
// Assumes: 32-bit AHB-Lite register window, word aligned
// Notes: offsets are byte addresses
`ifndef OWCD_DEFS_VH
`define OWCD_DEFS_VH

`define OWCD_OFS_WORD0 8'h00
`define OWCD_OFS_WORD1 8'h04
`define OWCD_OFS_WORD2 8'h08
`define OWCD_OFS_WORD3 8'h0c
`define OWCD_OFS_CTRL 8'h10
`define OWCD_OFS_STAT 8'h14
`define OWCD_OFS_ADCIN 8'h18
`define OWCD_OFS_ADCOUT 8'h1c

// Word 0 fields
`define OWCD_W0_DGL_HI 12
`define OWCD_W0_DGL_LO 11
`define OWCD_W0_SLOW 10
`define OWCD_W0_LPWR 9
`define OWCD_W0_LVR_HI 8
`define OWCD_W0_LVR_LO 7
`define OWCD_W0_RSTPIN 6
`define OWCD_W0_WDT 5
`define OWCD_W0_NRW 4
`define OWCD_W0_NRD 3
`define OWCD_W0_USED 16'h1ff8
// Word 1 fields
`define OWCD_W1_FSS 13
`define OWCD_W1_RCM_HI 6
`define OWCD_W1_RCM_LO 4
`define OWCD_W1_OSC_HI 3
`define OWCD_W1_OSC_LO 1
`define OWCD_W1_USED 16'h207e
// Word 2 fields
`define OWCD_W2_HOLDDIS 14
`define OWCD_W2_HCLK_HI 13
`define OWCD_W2_HCLK_LO 12
`define OWCD_W2_IRCPS 7
`define OWCD_W2_USED 16'h7080
// Word 3 fields
`define OWCD_W3_FILT 14
`define OWCD_W3_ADC_JUSTIFY_SEL 11
`define OWCD_W3_IRCDIR 8
`define OWCD_W3_CODE_RELOAD_ON 7
`define OWCD_W3_ID_HI 5
`define OWCD_W3_ID_LO 0
`define OWCD_W3_USED 16'h49bf

// Reset values (option words reset to zero; decoded widths reset to 32 and 8)
`define OWCD_WORD_RST 16'h0000

// Main oscillator codes
`define OWCD_OSC_IRC_IO 3'h0
`define OWCD_OSC_IRC_CK 3'h1
`define OWCD_OSC_HIGH_CRYSTAL_MODE_A 3'h2
`define OWCD_OSC_HIGH_CRYSTAL_MODE_B 3'h3
`define OWCD_OSC_XT 3'h4
`define OWCD_OSC_LXT 3'h5

// Deglitch, pulse rejection and undervolt dip timing
`define OWCD_DGL_OFF 2'h3
`define OWCD_NR_SHORT 6'h08
`define OWCD_NR_LONG 6'h20
`define OWCD_LVR_DIP_NS 5000
`define OWCD_CLK_NS 50
`define OWCD_LVR_DIP_CYC ((`OWCD_LVR_DIP_NS + `OWCD_CLK_NS - 1) / `OWCD_CLK_NS)
// Last count of the dip filter, one below the 100-cycle dip length
`define OWCD_LVR_DIP_LAST 13'h0063

`endif

//--- owcd_decode.v
// Purpose: option word loader and decoder with AHB-Lite register access
// Assumes: programmer sets every unused option bit to zero
// Notes: words are captured once after reset and then held
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "owcd_defs.vh"

module owcd_decode (
	input wire sys_clk,
	input wire rst_n,
	input wire clkEn,
	// Non-volatile option words as presented by the storage array
	input wire [15:0] nvmWord0,
	input wire [15:0] nvmWord1,
	input wire [15:0] nvmWord2,
	input wire [15:0] nvmWord3,
	// Run state from the core
	input wire greenMode,
	input wire idleMode,
	input wire sleepMode,
	input wire lxtActive,
	input wire supplyLow,
	// AHB-Lite slave
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	// Decoded settings
	output reg loaded,
	output reg [1:0] uartDeglitchSel,
	output reg deglitchBypass,
	output reg resetSlowMode,
	output reg lowPowerSel,
	output reg [1:0] undervoltLevelSel,
	output reg undervoltReset,
	output reg resetPinSel,
	output reg watchdogOn,
	output reg [5:0] pulseRejectCycles,
	output reg pulseRejectActive,
	output reg subOscFreqSel,
	output reg [2:0] ircFreqSel,
	output reg ircFreqReserved,
	output reg [2:0] mainOscModeSel,
	output reg clockOutPin,
	output reg oscModeReserved,
	output reg holdEnable,
	output reg [5:0] holdLengthClocks,
	output reg ircSupplySel,
	output reg inputFilterHeavy,
	output reg adcJustifySel,
	output reg [7:0] adcResultHigh,
	output reg [7:0] adcResultLow,
	output reg ircSpeedDir,
	output reg codeReloadOn,
	output reg [5:0] customerTag
);

	// ------------------------------------------------------------
	// Option word capture
	// ------------------------------------------------------------
	reg [15:0] word0;
	reg [15:0] word1;
	reg [15:0] word2;
	reg [15:0] word3;
	reg [11:0] adcRaw;
	reg [12:0] dipCount;
	reg unusedSet;

	// Captured once after reset release; asynchronous reset loads constants
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			word0 <= `OWCD_WORD_RST;
			word1 <= `OWCD_WORD_RST;
			word2 <= `OWCD_WORD_RST;
			word3 <= `OWCD_WORD_RST;
			loaded <= 1'b0;
			unusedSet <= 1'b0;
		end else if (clkEn && !loaded) begin
			word0 <= nvmWord0;
			word1 <= nvmWord1;
			word2 <= nvmWord2;
			word3 <= nvmWord3;
			loaded <= 1'b1;
			// Flag a programmer that broke the zero-fill convention
			unusedSet <= |(nvmWord0 & ~`OWCD_W0_USED) |
				|(nvmWord1 & ~`OWCD_W1_USED) |
				|(nvmWord2 & ~`OWCD_W2_USED) |
				|(nvmWord3 & ~`OWCD_W3_USED);
		end
	end

	// ------------------------------------------------------------
	// Static decode
	// ------------------------------------------------------------
	wire [2:0] oscCode = word1[`OWCD_W1_OSC_HI:`OWCD_W1_OSC_LO];
	wire lxtMode = (oscCode == `OWCD_OSC_LXT);

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			uartDeglitchSel <= 2'h0;
			deglitchBypass <= 1'b0;
			resetSlowMode <= 1'b0;
			lowPowerSel <= 1'b0;
			undervoltLevelSel <= 2'h0;
			resetPinSel <= 1'b0;
			watchdogOn <= 1'b0;
			pulseRejectCycles <= `OWCD_NR_LONG;
			pulseRejectActive <= 1'b0;
			subOscFreqSel <= 1'b0;
			ircFreqSel <= 3'h0;
			ircFreqReserved <= 1'b0;
			mainOscModeSel <= 3'h0;
			clockOutPin <= 1'b0;
			oscModeReserved <= 1'b0;
			holdEnable <= 1'b0;
			holdLengthClocks <= 6'h08;
			ircSupplySel <= 1'b0;
			inputFilterHeavy <= 1'b0;
			adcJustifySel <= 1'b0;
			ircSpeedDir <= 1'b0;
			codeReloadOn <= 1'b0;
			customerTag <= 6'h00;
		end else if (clkEn) begin
			uartDeglitchSel <= word0[`OWCD_W0_DGL_HI:`OWCD_W0_DGL_LO];
			deglitchBypass <= (word0[`OWCD_W0_DGL_HI:`OWCD_W0_DGL_LO] ==
				`OWCD_DGL_OFF);
			resetSlowMode <= word0[`OWCD_W0_SLOW];
			lowPowerSel <= word0[`OWCD_W0_LPWR];
			undervoltLevelSel <= word0[`OWCD_W0_LVR_HI:`OWCD_W0_LVR_LO];
			resetPinSel <= word0[`OWCD_W0_RSTPIN];
			watchdogOn <= word0[`OWCD_W0_WDT];
			// LOW_CRYSTAL_MODE fixes the count at 8 of the slow clock
			if (lxtMode || word0[`OWCD_W0_NRW])
				pulseRejectCycles <= `OWCD_NR_SHORT;
			else
				pulseRejectCycles <= `OWCD_NR_LONG;
			pulseRejectActive <= loaded && !word0[`OWCD_W0_NRD] &&
				!greenMode && !idleMode && !sleepMode;
			subOscFreqSel <= word1[`OWCD_W1_FSS];
			ircFreqSel <= word1[`OWCD_W1_RCM_HI:`OWCD_W1_RCM_LO];
			ircFreqReserved <= &word1[`OWCD_W1_RCM_HI:`OWCD_W1_RCM_LO];
			mainOscModeSel <= oscCode;
			clockOutPin <= (oscCode == `OWCD_OSC_IRC_CK);
			oscModeReserved <= (oscCode[2:1] == 2'h3);
			holdEnable <= loaded && !word2[`OWCD_W2_HOLDDIS];
			case (word2[`OWCD_W2_HCLK_HI:`OWCD_W2_HCLK_LO])
			2'h0: holdLengthClocks <= 6'h08;
			2'h1: holdLengthClocks <= 6'h04;
			2'h2: holdLengthClocks <= 6'h10;
			default: holdLengthClocks <= 6'h20;
			endcase
			ircSupplySel <= word2[`OWCD_W2_IRCPS];
			inputFilterHeavy <= word3[`OWCD_W3_FILT];
			adcJustifySel <= word3[`OWCD_W3_ADC_JUSTIFY_SEL];
			ircSpeedDir <= word3[`OWCD_W3_IRCDIR];
			codeReloadOn <= word3[`OWCD_W3_CODE_RELOAD_ON];
			customerTag <= word3[`OWCD_W3_ID_HI:`OWCD_W3_ID_LO];
		end
	end

	// ------------------------------------------------------------
	// Undervolt dip filter
	// ------------------------------------------------------------
	// Short dips are ignored; the comparator input must stay low
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dipCount <= 13'h0000;
			undervoltReset <= 1'b0;
		end else if (clkEn) begin
			if (!supplyLow || undervoltLevelSel == 2'h0) begin
				dipCount <= 13'h0000;
				undervoltReset <= 1'b0;
			end else if (dipCount >= `OWCD_LVR_DIP_LAST) begin
				undervoltReset <= 1'b1;
			end else begin
				dipCount <= dipCount + 13'h0001;
			end
		end
	end

	// ------------------------------------------------------------
	// ADC result packing
	// ------------------------------------------------------------
	always @* begin
		if (adcJustifySel) begin
			adcResultHigh = adcRaw[11:4];
			adcResultLow = {4'h0, adcRaw[3:0]};
		end else begin
			adcResultHigh = {4'h0, adcRaw[11:8]};
			adcResultLow = adcRaw[7:0];
		end
	end

	// ------------------------------------------------------------
	// AHB-Lite slave
	// ------------------------------------------------------------
	// Zero wait state: hreadyout is held high
	reg dataPhase;
	reg dataWrite;
	reg [7:0] dataAddr;
	wire addrValid = hsel && htrans[1] && hready;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dataPhase <= 1'b0;
			dataWrite <= 1'b0;
			dataAddr <= 8'h00;
		end else if (clkEn) begin
			dataPhase <= addrValid;
			dataWrite <= addrValid && hwrite;
			if (addrValid)
				dataAddr <= haddr;
		end
	end

	// Only the ADC input register is writable; option words stay fixed
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			adcRaw <= 12'h000;
		end else if (clkEn && dataPhase && dataWrite &&
			dataAddr == `OWCD_OFS_ADCIN) begin
			adcRaw <= hwdata[11:0];
		end
	end

	// Read data registered during the address phase
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h00000000;
		end else if (clkEn && addrValid && !hwrite) begin
			case (haddr)
			`OWCD_OFS_WORD0: hrdata <= {16'h0000, word0};
			`OWCD_OFS_WORD1: hrdata <= {16'h0000, word1};
			`OWCD_OFS_WORD2: hrdata <= {16'h0000, word2};
			`OWCD_OFS_WORD3: hrdata <= {16'h0000, word3};
			`OWCD_OFS_STAT: hrdata <= {28'h0000000, undervoltReset,
				pulseRejectActive, unusedSet, loaded};
			`OWCD_OFS_ADCIN: hrdata <= {20'h00000, adcRaw};
			`OWCD_OFS_ADCOUT: hrdata <= {16'h0000, adcResultHigh,
				adcResultLow};
			default: hrdata <= 32'h00000000;
			endcase
		end
	end

endmodule

//--- owcd_decode_assertions.sv
// Purpose: temporal checks on the option word decoder ports
// Assumes: clkEn held high, option words still while loaded
// Notes: attached to every decoder instance by bind
`timescale 1ns/1ps
module owcd_checker (
	input wire sys_clk,
	input wire rst_n,
	input wire greenMode,
	input wire idleMode,
	input wire sleepMode,
	input wire supplyLow,
	input wire loaded,
	input wire [1:0] uartDeglitchSel,
	input wire deglitchBypass,
	input wire [1:0] undervoltLevelSel,
	input wire undervoltReset,
	input wire [5:0] pulseRejectCycles,
	input wire pulseRejectActive,
	input wire [2:0] mainOscModeSel,
	input wire clockOutPin,
	input wire oscModeReserved,
	input wire [5:0] holdLengthClocks
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_bypass_code: assert property (
		deglitchBypass == (uartDeglitchSel == 2'h3)) else $error("bypass wrong");
	a_undervolt_off: assert property (
		undervoltReset |-> undervoltLevelSel != 2'h0) else $error("trip at code 00");
	a_dip_release: assert property (
		!supplyLow |=> !undervoltReset) else $error("trip outlived dip");
	// A trip needs the supply low well before it, short dips pass
	a_dip_short: assert property (
		$rose(undervoltReset) |-> $past(supplyLow, 90)) else $error("short dip trip");
	a_reject_modes: assert property (
		greenMode || idleMode || sleepMode |=> !pulseRejectActive)
		else $error("rejection on in low power mode");
	a_lxt_width: assert property (
		$past(loaded) && mainOscModeSel == 3'h5 |-> pulseRejectCycles == 6'h08)
		else $error("crystal width not 8");
	a_osc_flags: assert property (
		clockOutPin == (mainOscModeSel == 3'h1) &&
		oscModeReserved == (mainOscModeSel[2:1] == 2'h3)) else $error("osc flags");
	a_settings_held: assert property (
		loaded && $past(loaded) |=>
		$stable({uartDeglitchSel, mainOscModeSel, holdLengthClocks}))
		else $error("settings moved after load");
	c_lxt: cover property (loaded && mainOscModeSel == 3'h5);
	c_trip: cover property ($rose(undervoltReset));
	c_low_mode: cover property (greenMode && !pulseRejectActive);
endmodule
bind owcd_decode owcd_checker u_check (.*);

//--- owcd_programmer.sv
// Purpose: stand-in for the programmer that burns the option words
// Assumes: words are burnt while the decoder sits in reset
// Notes: a burn without reset must not reach the settings
`timescale 1ns/1ps
`include "owcd_defs.vh"
module owcd_programmer (
	output logic [15:0] nvmWord0,
	output logic [15:0] nvmWord1,
	output logic [15:0] nvmWord2,
	output logic [15:0] nvmWord3
);
	// Unused positions always burnt low, whatever image is asked for
	task automatic burn(input logic [63:0] img);
		{nvmWord0, nvmWord1, nvmWord2, nvmWord3} <= img & {
			`OWCD_W0_USED, `OWCD_W1_USED, `OWCD_W2_USED, `OWCD_W3_USED};
	endtask
endmodule

//--- owcd_decode_tb.sv
// Purpose: self-checking bench for the option word decoder
// Assumes: hready loops back from hreadyout, clkEn held high
// Notes: each pass burns, resets, checks, reburns and checks again
`timescale 1ns/1ps
`include "owcd_defs.vh"
module owcd_decode_tb;
	logic sys_clk = 1'b0, rst_n = 1'b0, supplyLow = 1'b0, hsel = 1'b0;
	logic greenMode = 1'b0, idleMode = 1'b0, sleepMode = 1'b0, hwrite = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, rdData, rnd;
	logic [15:0] w [4];
	logic [5:0] holdTab [4] = '{6'h08, 6'h04, 6'h10, 6'h20};
	logic [31:0] expQ [$];
	event rdEv;
	integer seed = 86927;
	int errors = 0, checks = 0;
	wire [31:0] hrdata;
	wire [15:0] nvmWord0, nvmWord1, nvmWord2, nvmWord3;
	wire [7:0] adcResultHigh, adcResultLow;
	wire [5:0] pulseRejectCycles, holdLengthClocks, customerTag;
	wire [2:0] ircFreqSel, mainOscModeSel;
	wire [1:0] uartDeglitchSel, undervoltLevelSel;
	wire hreadyout, hresp, loaded, deglitchBypass, resetSlowMode, lowPowerSel;
	wire undervoltReset, resetPinSel, watchdogOn, pulseRejectActive;
	wire subOscFreqSel, ircFreqReserved, clockOutPin, oscModeReserved;
	wire holdEnable, ircSupplySel, inputFilterHeavy, adcJustifySel;
	wire ircSpeedDir, codeReloadOn;
	wire hready = hreadyout;
	wire clkEn = 1'b1;
	wire lxtActive = 1'b0;
	wire [2:0] hsize = 3'h2;
	owcd_decode DUT (.*);
	owcd_programmer prog (.*);
	initial forever #25 sys_clk = ~sys_clk;
	task automatic chk(input string nm, input logic [31:0] exp, got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Each phase is held until hready is seen high at an edge
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, input logic [31:0] exp);
		int n;
		n = 0;
		@(posedge sys_clk);
		{hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, wr};
		do @(posedge sys_clk); while (hready !== 1'b1 && ++n < 50);
		{htrans, hwdata} <= {2'h0, wd};
		do @(posedge sys_clk); while (hready !== 1'b1 && ++n < 100);
		if (n >= 50)
			errors++;
		if (!wr) begin
			rdData = hrdata;
			expQ.push_back(exp);
			->rdEv;
		end
	endtask
	always @(rdEv) chk("bus read", expQ.pop_front(), rdData);
	task automatic checkAll;
		logic [15:0] a, b, c, d;
		logic act;
		logic [31:0] adc;
		a = w[0];
		b = w[1];
		c = w[2];
		d = w[3];
		act = !a[3] && !(greenMode || idleMode || sleepMode);
		chk("word0 word1 fields",
			{6'h0, uartDeglitchSel, deglitchBypass, resetSlowMode,
			lowPowerSel, undervoltLevelSel, resetPinSel, watchdogOn,
			pulseRejectCycles, pulseRejectActive, subOscFreqSel, ircFreqSel,
			ircFreqReserved, mainOscModeSel, clockOutPin, oscModeReserved},
			{6'h0, a[12:11], &a[12:11], a[10:5],
			((a[4] || b[3:1] == 3'h5) ? 6'h08 : 6'h20), act, b[13], b[6:4],
			&b[6:4], b[3:1], (b[3:1] == 3'h1), &b[3:2]});
		chk("word2 word3 fields",
			{14'h0, holdEnable, holdLengthClocks, ircSupplySel,
			inputFilterHeavy, adcJustifySel, ircSpeedDir, codeReloadOn,
			customerTag}, {14'h0, !c[14], holdTab[c[13:12]], c[7], d[14],
			d[11], d[8], d[7], d[5:0]});
		ahb(1'b1, 8'h00, 32'h0000ffff, 32'h0);
		for (int i = 0; i < 4; i++)
			ahb(1'b0, 8'(4 * i), 32'h0, {16'h0, w[i]});
		ahb(1'b0, 8'h10, 32'h0, 32'h0);
		ahb(1'b0, 8'h14, 32'h0, {29'h0, act, 2'h1});
		rnd = $random(seed);
		adc = d[11] ? {16'h0, rnd[11:4], 4'h0, rnd[3:0]} : {20'h0, rnd[11:0]};
		ahb(1'b1, 8'h18, rnd, 32'h0);
		ahb(1'b0, 8'h18, 32'h0, {20'h0, rnd[11:0]});
		ahb(1'b0, 8'h1c, 32'h0, adc);
		chk("adc result", adc, {16'h0, adcResultHigh, adcResultLow});
	endtask
	initial begin
		for (int n = 0; n < 8; n++) begin
			rnd = $random(seed);
			{w[0], w[1], w[2], w[3]} = {rnd, $random(seed)} & {`OWCD_W0_USED,
				`OWCD_W1_USED, `OWCD_W2_USED, `OWCD_W3_USED};
			if (n == 0)
				{w[0], w[1], w[2], w[3]} = 64'h0;
			// Loop index walks every code of the multi-bit fields except the word 3 ID, which stays random
			w[0][12:11] = n[1:0];
			w[0][8:7] = n[2:1];
			w[1][6:4] = n[2:0];
			w[1][3:1] = 3'h7 - n[2:0];
			w[2][13:12] = n[1:0];
			{greenMode, idleMode, sleepMode} <= n[2] ? rnd[2:0] : 3'h0;
			prog.burn({w[0], w[1], w[2], w[3]});
			rst_n <= 1'b0;
			repeat (12) @(posedge sys_clk);
			chk("reset state", {18'h0, loaded, pulseRejectCycles,
				holdLengthClocks, undervoltReset}, {19'h0, 6'h20, 6'h08, 1'b0});
			rst_n <= 1'b1;
			repeat (3) @(posedge sys_clk);
			checkAll();
			prog.burn(~{w[0], w[1], w[2], w[3]});
			repeat (2) @(posedge sys_clk);
			checkAll();
			supplyLow <= 1'b1;
			repeat (90) @(posedge sys_clk);
			chk("short dip", {31'h0, undervoltReset}, 32'h0);
			repeat (20) @(posedge sys_clk);
			chk("long dip", {31'h0, undervoltReset},
				{31'h0, w[0][8:7] != 2'h0});
			supplyLow <= 1'b0;
			repeat (2) @(posedge sys_clk);
			chk("dip over", {31'h0, undervoltReset}, 32'h0);
		end
		results();
	end
	initial begin
		repeat (8000) @(posedge sys_clk);
		errors++;
		results();
	end
	task automatic results;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
endmodule
